/* bench/air_assertions.sv */
// Port checker for the interrupt router
`timescale 1ns/100ps
`default_nettype none
module air_assertions (
	// Watched ports
	input wire logic mclk, rst_n, reg_wr, wake_request, in_sleep,
	input wire logic evt_orientation, evt_freefall_motion, evt_sample_ready,
	input wire logic auto_sleep_enable, clk_en,
	input wire logic [7:0] reg_addr, reg_wdata, reg_rdata
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	// Write, then a read of the same place on the next edge
	sequence s_wr(a);
		clk_en && reg_wr && reg_addr == a ##1
		clk_en && !reg_wr && reg_addr == a;
	endsequence
	chk_ctrl_back: assert property (s_wr(8'h2C) |=>
		reg_rdata == ($past(reg_wdata, 2) & 8'h2B)) else $error("ctrl");
	chk_en_back: assert property (s_wr(8'h2D) |=>
		reg_rdata == ($past(reg_wdata, 2) & 8'h95)) else $error("enable");
	chk_route_back: assert property (s_wr(8'h2E) |=>
		reg_rdata == ($past(reg_wdata, 2) & 8'h95)) else $error("route");
	chk_unmapped_rd: assert property (
		clk_en && reg_addr == 8'h2F |=> reg_rdata == 8'h00)
		else $error("unmapped");
	chk_status_mask: assert property (
		clk_en && reg_addr == 8'h0C |=> (reg_rdata & 8'h6A) == 8'h00)
		else $error("mask");
	chk_status_src: assert property (
		clk_en && reg_addr == 8'h0C && !evt_sample_ready |=> !reg_rdata[0])
		else $error("status");
	chk_wake_gate: assert property (
		clk_en && !(auto_sleep_enable && in_sleep) |=> !wake_request)
		else $error("gate");
	chk_wake_cause: assert property (
		clk_en && !evt_orientation && !evt_freefall_motion |=> !wake_request)
		else $error("wake");
endmodule // air_assertions
`default_nettype wire

/* bench/air_host_model.sv */
// Host side: interrupt lines with pull-ups
`timescale 1ns/100ps
`default_nettype none
module air_host_model (
	// Router pins and resolved lines
	input wire logic irq_pin_a_o, irq_pin_a_oe, irq_pin_b_o, irq_pin_b_oe,
	output logic line_a, line_b
);
	// Released lines float high, so open drain can share a line
	assign line_a = irq_pin_a_oe ? irq_pin_a_o : 1'b1;
	assign line_b = irq_pin_b_oe ? irq_pin_b_o : 1'b1;
endmodule // air_host_model
`default_nettype wire

/* bench/air_router_tb.sv */
// Random bench for the interrupt router
`timescale 1ns/100ps
`default_nettype none
module air_router_tb;
	logic mclk = 0, rst_n = 0, clk_en = 1, reg_wr = 0, in_sleep = 0;
	logic auto_sleep_enable = 0, evt_sleep_wake = 0, evt_orientation = 0;
	logic evt_freefall_motion = 0, evt_sample_ready = 0, xa = 1, xb = 1;
	logic wake_request, irq_pin_a_o, irq_pin_a_oe, irq_pin_b_o, irq_pin_b_oe;
	logic line_a, line_b, xw = 0, xoa = 1, xob = 1;
	logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata, c = 0, e = 0, r = 0;
	logic [7:0] v, xr = 0;
	int fail_count = 0, n_checks = 0, u;
	air_router uut (.*);
	air_host_model host (.*);
	// Line level from the shared polarity and drive bits
	function logic lv(logic a);
		return a ? c[1] : c[0] | !c[1];
	endfunction
	task chk(string n, logic [7:0] s, logic [7:0] x);
		n_checks++;
		if (s !== x) begin
			fail_count++;
			$display("wrong value %s exp %h got %h", n, x, s);
		end
	endtask
	task final_report;
		if (fail_count == 0 && n_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	initial forever #2.5 mclk = ~mclk;
	// Watchdog well past the 3000 cycle run
	initial begin
		#20000;
		fail_count++;
		final_report;
	end
	// Random traffic; expectations settle one edge later
	initial begin
		u = $urandom(32'hbf53_346c);
		repeat (2) @(negedge mclk);
		rst_n = 1;
		for (int i = 0; i < 3000; i++) begin
			@(negedge mclk);
			chk("a", line_a, xa);
			chk("b", line_b, xb);
			chk("a_oe", irq_pin_a_oe, xoa);
			chk("b_oe", irq_pin_b_oe, xob);
			chk("wake", wake_request, xw);
			chk("rd", reg_rdata, xr);
			u = $urandom;
			// Now and then all sources fire at once
			if (i % 50 == 0) u[6:3] = 4'hf;
			{evt_sleep_wake, evt_orientation, evt_freefall_motion,
				evt_sample_ready, auto_sleep_enable, in_sleep, reg_wr} = u[6:0];
			reg_addr = u[10:8] > 4 ? 8'h0C : 8'h2C + 8'(u[10:8]);
			reg_wdata = u[31:24];
			// Enable drops on about one edge in eight; one reset mid-run
			clk_en = u[14:12] != 3'h0;
			rst_n = i != 1500;
			v = {evt_sleep_wake, 2'b00, evt_orientation, 1'b0,
				evt_freefall_motion, 1'b0, evt_sample_ready} & e;
			if (!rst_n) begin
				// Reset clears every register and idles both lines high
				{c, e, r, xr} = 32'h0000_0000;
				{xa, xb, xoa, xob, xw} = 5'h1e;
			end else if (clk_en) begin
				xa = lv(|(v & r));
				xb = lv(|(v & ~r));
				xoa = !c[0] | |(v & r);
				xob = !c[0] | |(v & ~r);
				xw = auto_sleep_enable & in_sleep
					& (c[5] & evt_orientation | c[3] & evt_freefall_motion);
				xr = reg_addr == 8'h2C ? c : reg_addr == 8'h2D ? e :
					reg_addr == 8'h2E ? r : reg_addr == 8'h0C ? v : 8'h00;
				if (reg_wr && reg_addr == 8'h2C) c = reg_wdata & 8'h2B;
				if (reg_wr && reg_addr == 8'h2D) e = reg_wdata & 8'h95;
				if (reg_wr && reg_addr == 8'h2E) r = reg_wdata & 8'h95;
			end
		end
		final_report;
	end
endmodule // air_router_tb
bind air_router air_assertions mon (.*);
`default_nettype wire

/* design/air_pin_drive.sv */
// One interrupt pin driver: polarity and push-pull or open-drain
`timescale 1ns/100ps
`default_nettype none
module air_pin_drive (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic clk_en,
	// Request and configuration
	input wire logic active,
	input wire logic polarity,
	input wire logic drive_sel,
	// Pin
	output logic pin_o,
	output logic pin_oe
);
	logic level_q;
	logic oe_q;

	// Registered pin level; at reset the idle level for active low
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			level_q <= 1'b1;
		end else if (clk_en) begin
			level_q <= polarity ? active : ~active;
		end
	end

	// Open-drain drives only while asserted and releases otherwise
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			oe_q <= 1'b1;
		end else if (clk_en) begin
			oe_q <= drive_sel ? active : 1'b1;
		end
	end

	assign pin_o = level_q;
	assign pin_oe = oe_q;
endmodule // air_pin_drive
`default_nettype wire

/* design/air_router.sv */
// Interrupt router: enables, routing, polarity, drive and sleep wake
// Function
// - Orientation wake bit 5 set lets an orientation event wake from sleep.
// - Freefall/motion wake bit 3 set lets that event wake from sleep.
// - Polarity bit 1 chooses active low (0, default) or high (1) pins.
// - Drive bit 0 chooses push-pull (0, default) or open-drain (1) pins.
// - Enable register holds enables at bits 7, 4, 2 and 0, all reset 0.
// - Only enabled sources pass their flags on to a pin.
// - Routing bit 0 sends a source to pin b, 1 sends it to pin a.
// - Routing register uses the enable layout and resets to pin b.
// - Many sources may share a pin; host reads the source status at 0x0C.
// - Wake bits act only while auto-sleep is enabled.
`timescale 1ns/100ps
`default_nettype none
module air_router
	import air_pkg::*;
(
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic clk_en,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	// Event flags from the functional blocks
	input wire logic evt_sleep_wake,
	input wire logic evt_orientation,
	input wire logic evt_freefall_motion,
	input wire logic evt_sample_ready,
	// Sleep state
	input wire logic auto_sleep_enable,
	input wire logic in_sleep,
	output logic wake_request,
	// Interrupt pins
	output logic irq_pin_a_o,
	output logic irq_pin_a_oe,
	output logic irq_pin_b_o,
	output logic irq_pin_b_oe
);
	logic [7:0] ctrl_q;
	logic [7:0] enable_q;
	logic [7:0] routing_q;
	logic [7:0] events;
	logic [7:0] gated;
	logic [7:0] to_a;
	logic [7:0] to_b;
	logic wake_q;
	logic [7:0] rdata_q;
	logic sleep_armed;
	logic wake_orient;
	logic wake_ffmt;
	logic pin_a_active;
	logic pin_b_active;

	// Write strike for one register. The clock enable is part of the decode
	// so that a frozen block ignores the bus as well as its events.
	function automatic logic wr_hit(
		logic en,
		logic wr,
		logic [7:0] addr,
		logic [7:0] ofs
	);
		return en && wr && addr == ofs;
	endfunction

	// One-hot bit for a source or field position
	function automatic logic [7:0] field_bit(int pos);
		return 8'h01 << pos;
	endfunction

	// Sources headed for one pin: routing bit 1 means pin a, 0 means pin b
	function automatic logic [7:0] sources_for(
		logic [7:0] src,
		logic [7:0] route,
		logic want_a
	);
		return src & (want_a ? route : ~route);
	endfunction

	// Build-time checks on the field layout. The event vector, the masks and
	// the read-back all lean on these positions, so a package edit that makes
	// them disagree stops the build instead of routing the wrong source.
	if (AIR_MASK_SRC != (field_bit(AIR_BIT_SLEEP_WAKE) |
		field_bit(AIR_BIT_ORIENT) | field_bit(AIR_BIT_FFMT) |
		field_bit(AIR_BIT_SAMPLE_RDY))) begin : g_bad_src_mask
		$error("source mask disagrees with the source positions");
	end
	if (AIR_MASK_CTRL != (field_bit(AIR_BIT_WAKE_ORIENT) |
		field_bit(AIR_BIT_WAKE_FFMT) | field_bit(AIR_BIT_POLARITY) |
		field_bit(AIR_BIT_DRIVE_SEL))) begin : g_bad_ctrl_mask
		$error("control mask disagrees with the control fields");
	end
	// A reset value may not set a bit that a write could never set
	if ((AIR_RST_ENABLE & ~AIR_MASK_SRC) != 8'h00 ||
		(AIR_RST_ROUTING & ~AIR_MASK_SRC) != 8'h00 ||
		(AIR_RST_CTRL & ~AIR_MASK_CTRL) != 8'h00) begin : g_bad_reset
		$error("a reset value sets a bit that cannot be written");
	end
	// Shared offsets would give the read mux duplicate items
	if (AIR_OFS_PIN_WAKE_CTRL == AIR_OFS_SRC_ENABLE ||
		AIR_OFS_SRC_ENABLE == AIR_OFS_PIN_ROUTING ||
		AIR_OFS_PIN_ROUTING == AIR_OFS_PIN_WAKE_CTRL ||
		AIR_OFS_SOURCE_STATUS == AIR_OFS_PIN_WAKE_CTRL ||
		AIR_OFS_SOURCE_STATUS == AIR_OFS_SRC_ENABLE ||
		AIR_OFS_SOURCE_STATUS == AIR_OFS_PIN_ROUTING) begin : g_bad_ofs
		$error("two registers share one offset");
	end

	// Source flags placed at their register positions
	always_comb begin
		events = 8'h00;
		events[AIR_BIT_SLEEP_WAKE] = evt_sleep_wake;
		events[AIR_BIT_ORIENT] = evt_orientation;
		events[AIR_BIT_FFMT] = evt_freefall_motion;
		events[AIR_BIT_SAMPLE_RDY] = evt_sample_ready;
	end

	// Control register: wake bits, polarity, drive. Bits outside the mask
	// are dropped on write, so they always read back as zero.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_q <= AIR_RST_CTRL;
		end else if (wr_hit(clk_en, reg_wr, reg_addr,
			AIR_OFS_PIN_WAKE_CTRL)) begin
			ctrl_q <= reg_wdata & AIR_MASK_CTRL;
		end
	end

	// Enable register; unused bits kept at zero so a stray write to them
	// can never open a source that does not exist
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			enable_q <= AIR_RST_ENABLE;
		end else if (wr_hit(clk_en, reg_wr, reg_addr,
			AIR_OFS_SRC_ENABLE)) begin
			enable_q <= reg_wdata & AIR_MASK_SRC;
		end
	end

	// Routing register, same layout as enable; zero after reset, which
	// sends every source to pin b until the host says otherwise
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			routing_q <= AIR_RST_ROUTING;
		end else if (wr_hit(clk_en, reg_wr, reg_addr,
			AIR_OFS_PIN_ROUTING)) begin
			routing_q <= reg_wdata & AIR_MASK_SRC;
		end
	end

	// Gate by enable: a disabled source never reaches a pin or the status
	assign gated = events & enable_q;
	// Split by routing bit
	assign to_a = sources_for(gated, routing_q, 1'b1);
	assign to_b = sources_for(gated, routing_q, 1'b0);

	// Each pin is the OR of the enabled sources routed to it. Several
	// sources may share a pin; the status read is how the host tells them
	// apart, so nothing here is latched or prioritised.
	assign pin_a_active = |to_a;
	assign pin_b_active = |to_b;

	// Wake terms: each wake bit lets only its own event through. The
	// interrupt enables are kept out of this path on purpose, so a part may
	// be woken by motion while both pins stay quiet.
	assign sleep_armed = auto_sleep_enable && in_sleep;
	assign wake_orient = ctrl_q[AIR_BIT_WAKE_ORIENT] &&
		evt_orientation;
	assign wake_ffmt = ctrl_q[AIR_BIT_WAKE_FFMT] &&
		evt_freefall_motion;

	// Wake request is registered; it only asks, leaving sleep is elsewhere
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			wake_q <= 1'b0;
		end else if (clk_en) begin
			wake_q <= sleep_armed && (wake_orient || wake_ffmt);
		end
	end
	assign wake_request = wake_q;

	// Read mux; status shows gated sources so the host can tell who fired
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_q <= 8'h00;
		end else if (clk_en) begin
			case (reg_addr)
				AIR_OFS_PIN_WAKE_CTRL: rdata_q <= ctrl_q;
				AIR_OFS_SRC_ENABLE: rdata_q <= enable_q;
				AIR_OFS_PIN_ROUTING: rdata_q <= routing_q;
				AIR_OFS_SOURCE_STATUS: rdata_q <= gated;
				default: rdata_q <= 8'h00;
			endcase
		end
	end
	assign reg_rdata = rdata_q;

	// Pin a driver. Both pins share one polarity and one drive mode, so a
	// board that ties them together has to run them open drain.
	air_pin_drive u_pin_a (
		.mclk(mclk),
		.rst_n(rst_n),
		.clk_en(clk_en),
		.active(pin_a_active),
		.polarity(ctrl_q[AIR_BIT_POLARITY]),
		.drive_sel(ctrl_q[AIR_BIT_DRIVE_SEL]),
		.pin_o(irq_pin_a_o),
		.pin_oe(irq_pin_a_oe)
	);

	// Pin b driver; the default target, since routing resets to zero
	air_pin_drive u_pin_b (
		.mclk(mclk),
		.rst_n(rst_n),
		.clk_en(clk_en),
		.active(pin_b_active),
		.polarity(ctrl_q[AIR_BIT_POLARITY]),
		.drive_sel(ctrl_q[AIR_BIT_DRIVE_SEL]),
		.pin_o(irq_pin_b_o),
		.pin_oe(irq_pin_b_oe)
	);
endmodule // air_router
`default_nettype wire

/* include/air_pkg.sv */
// Package of offsets, field positions and reset values for the interrupt router
package air_pkg;
	// Register offsets
	localparam logic [7:0] AIR_OFS_PIN_WAKE_CTRL = 8'h2C;
	localparam logic [7:0] AIR_OFS_SRC_ENABLE = 8'h2D;
	localparam logic [7:0] AIR_OFS_PIN_ROUTING = 8'h2E;
	localparam logic [7:0] AIR_OFS_SOURCE_STATUS = 8'h0C;
	// Pin and wake control fields
	localparam int AIR_BIT_WAKE_ORIENT = 5;
	localparam int AIR_BIT_WAKE_FFMT = 3;
	localparam int AIR_BIT_POLARITY = 1;
	localparam int AIR_BIT_DRIVE_SEL = 0;
	// Source positions shared by enable and routing registers
	localparam int AIR_BIT_SLEEP_WAKE = 7;
	localparam int AIR_BIT_ORIENT = 4;
	localparam int AIR_BIT_FFMT = 2;
	localparam int AIR_BIT_SAMPLE_RDY = 0;
	// Writable bit masks; other bits read as zero
	localparam logic [7:0] AIR_MASK_CTRL = 8'h2B;
	localparam logic [7:0] AIR_MASK_SRC = 8'h95;
	// Reset values
	localparam logic [7:0] AIR_RST_CTRL = 8'h00;
	localparam logic [7:0] AIR_RST_ENABLE = 8'h00;
	localparam logic [7:0] AIR_RST_ROUTING = 8'h00;
endpackage
